// *** hdl/sib_bridge_status.v ***
// Bridge status and read-byte registers for the Bridge_status EEPROM path
`timescale 1ns/1ps
module sib_bridge_status #(
  parameter PAGE_MASK = 8'h3F
)(
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire cmd_wr,
  input wire cmd_rd,
  input wire done_ok,
  input wire done_abort,
  input wire byte_rx,
  input wire [7:0] byte_in,
  input wire byte_wr,
  input wire [7:0] byte_wr_addr,
  output reg eesize_xfer,
  output wire eesize_now
);
  `include "sib_map.vh"
  reg eesize_r;
  wire wdone_w;
  wire tabort_w;
  wire pdone_w;
  wire rdvalid_w;
  wire [7:0] rbyte_w;
  wire [7:0] status_w;
  reg [7:0] rdata_nxt;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function sib_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      sib_hit = (addr == off);
    end
  endfunction

  // ---------------------------------------------------------------
  // Flag tracker
  // ---------------------------------------------------------------
  sib_flags #(.PAGE_MASK(PAGE_MASK)) u_flags (
    .mclk(mclk),
    .rst(rst),
    .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd),
    .done_ok(done_ok),
    .done_abort(done_abort),
    .byte_rx(byte_rx),
    .byte_in(byte_in),
    .byte_wr(byte_wr),
    .byte_wr_addr(byte_wr_addr),
    .wdone_r(wdone_w),
    .tabort_r(tabort_w),
    .pdone_r(pdone_w),
    .rdvalid_r(rdvalid_w),
    .rbyte_r(rbyte_w)
  );

  // ---------------------------------------------------------------
  // Address-size control
  // ---------------------------------------------------------------
  // Sampled at command start so a running transfer keeps its own size.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      eesize_r <= `SIB_RST_EESIZE;
      eesize_xfer <= `SIB_RST_EESIZE;
    end
    else
    begin
      if (reg_wr && sib_hit(reg_addr, `SIB_OFF_STATUS))
        eesize_r <= reg_wdata[`SIB_BIT_EESIZE];
      if (cmd_wr || cmd_rd)
        eesize_xfer <= eesize_r;
    end
  end
  assign eesize_now = eesize_r;

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  assign status_w = {3'h0, eesize_r, rdvalid_w, pdone_w, tabort_w, wdone_w};

  // Data stand only in the cycle after the strobe; zero otherwise
  always @*
  begin
    rdata_nxt = `SIB_ZERO8;
    if (reg_rd && sib_hit(reg_addr, `SIB_OFF_STATUS))
      rdata_nxt = status_w;
    else if (reg_rd && sib_hit(reg_addr, `SIB_OFF_RBYTE))
      rdata_nxt = rbyte_w;
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      reg_rdata <= `SIB_ZERO8;
    else
      reg_rdata <= rdata_nxt;
  end
endmodule // sib_bridge_status

// *** hdl/sib_flags.v ***
// Status flag tracker for bridged EEPROM transfers
`timescale 1ns/1ps
module sib_flags #(
  parameter PAGE_MASK = 8'h3F
)(
  input wire mclk,
  input wire rst,
  input wire cmd_wr,
  input wire cmd_rd,
  input wire done_ok,
  input wire done_abort,
  input wire byte_rx,
  input wire [7:0] byte_in,
  input wire byte_wr,
  input wire [7:0] byte_wr_addr,
  output reg wdone_r,
  output reg tabort_r,
  output reg pdone_r,
  output reg rdvalid_r,
  output reg [7:0] rbyte_r
);
  `include "sib_map.vh"
  reg wr_pend_r;
  reg rd_pend_r;

  // ---------------------------------------------------------------
  // Flag sequencing
  // ---------------------------------------------------------------
  // A new command in the same cycle as a completion wins: the completion
  // belongs to the old transfer.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wdone_r <= 1'b0;
      tabort_r <= 1'b0;
      pdone_r <= 1'b0;
      rdvalid_r <= 1'b0;
      rbyte_r <= `SIB_RST_RBYTE;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end
    else
    begin
      if (byte_wr)
        pdone_r <= ((byte_wr_addr & PAGE_MASK) == PAGE_MASK);
      if (cmd_wr || cmd_rd)
      begin
        tabort_r <= 1'b0;
        wr_pend_r <= cmd_wr;
        rd_pend_r <= cmd_rd;
        if (cmd_wr)
          wdone_r <= 1'b0;
        if (cmd_rd)
          rdvalid_r <= 1'b0;
      end
      else
      begin
        if (done_abort && (wr_pend_r || rd_pend_r))
        begin
          tabort_r <= 1'b1;
          wdone_r <= 1'b0;
          rdvalid_r <= 1'b0;
          wr_pend_r <= 1'b0;
          rd_pend_r <= 1'b0;
        end
        else
        begin
          if (done_ok && wr_pend_r)
          begin
            wdone_r <= 1'b1;
            wr_pend_r <= 1'b0;
          end
          if (byte_rx && rd_pend_r)
          begin
            rbyte_r <= byte_in;
            rdvalid_r <= 1'b1;
            rd_pend_r <= 1'b0;
          end
        end
      end
    end
  end
endmodule // sib_flags

// *** hdl/sib_map.vh ***
// Register map and field constants for the bridge status block
`ifndef SIB_MAP_VH
`define SIB_MAP_VH
`define SIB_ADDR_W 8
`define SIB_OFF_STATUS 8'h58
`define SIB_OFF_RBYTE 8'h59
`define SIB_BIT_WDONE 0
`define SIB_BIT_TABORT 1
`define SIB_BIT_PDONE 2
`define SIB_BIT_RDVALID 3
`define SIB_BIT_EESIZE 4
`define SIB_RST_STATUS 8'h10
`define SIB_RST_RBYTE 8'h00
`define SIB_RST_EESIZE 1'h1
`define SIB_ZERO8 8'h00
`define SIB_PAGE_LAST 8'hFF
`endif

// *** verif/sib_chk_monitor.sv ***
// Port checker for the bridge status block
`timescale 1ns/1ps
module sib_chk(
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire cmd_wr,
  input wire cmd_rd,
  input wire eesize_xfer,
  input wire eesize_now
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire st = reg_rd && reg_addr == 8'h58;
  wire sw = reg_wr && reg_addr == 8'h58;
  wire cm = cmd_wr || cmd_rd;
  wire um = reg_rd && reg_addr != 8'h58 && reg_addr != 8'h59;
  abort_wdone_a: assert property (st |=> !(reg_rdata[1] && reg_rdata[0])) else $error("clash");
  abort_rdvalid_a: assert property (st |=> !(reg_rdata[1] && reg_rdata[3])) else $error("clash");
  resv_zero_a: assert property (st |=> reg_rdata[7:5] == 3'h0) else $error("reserved set");
  unmapped_zero_a: assert property (um |=> reg_rdata == 8'h00) else $error("unmapped data");
  size_write_a: assert property (sw |=> eesize_now == $past(reg_wdata[4])) else $error("size lost");
  size_hold_a: assert property (!sw |=> $stable(eesize_now)) else $error("size moved");
  size_read_a: assert property (st |=> reg_rdata[4] == $past(eesize_now)) else $error("size read");
  xfer_latch_a: assert property (cm |=> eesize_xfer == $past(eesize_now)) else $error("latch");
  xfer_hold_a: assert property (!cm |=> $stable(eesize_xfer)) else $error("xfer moved");
  cover property (sw ##1 cm);
  cover property (st ##1 reg_rdata[3]);
  cover property (st ##1 reg_rdata[1]);
endmodule // sib_chk
bind sib_bridge_status sib_chk u_chk(.*);

// *** verif/sib_eeprom_model.sv ***
// Far-side model: follows the bench commands and gives I2C EEPROM answers
`timescale 1ns/1ps
module sib_eeprom_model(
  input wire mclk,
  input wire cmd_wr,
  input wire cmd_rd,
  input wire abort,
  input wire [7:0] a,
  input wire [7:0] d,
  output reg done_ok = 1'b0,
  output reg done_abort = 1'b0,
  output reg byte_rx = 1'b0,
  output reg byte_wr = 1'b0,
  output reg [7:0] byte_in = 8'h00,
  output reg [7:0] byte_wr_addr = 8'h00
);
  reg [1:0] wk = 2'h0;
  reg [1:0] rk = 2'h0;
  always @(posedge mclk)
  begin
    wk <= {wk[0], cmd_wr};
    rk <= {rk[0], cmd_rd};
    {done_ok, done_abort, byte_rx, byte_wr} <= 4'h0;
    byte_in <= ~byte_in; // Stale bytes must never look valid
    byte_wr_addr <= ~byte_wr_addr;
    if (wk[0])
      {byte_wr, byte_wr_addr} <= {1'b1, a};
    if (wk[1] | rk[1])
      {done_ok, done_abort} <= {wk[1] & !abort, abort};
    if (rk[1] & !abort)
      {byte_rx, byte_in} <= {1'b1, d};
  end
endmodule // sib_eeprom_model

// *** verif/tb_top.sv ***
// Self-checking bench for the bridge status block
`timescale 1ns/1ps
module tb_top;
  reg mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, cmd_wr = 0, cmd_rd = 0, abort = 0;
  reg [7:0] reg_addr = 0, reg_wdata = 0, a = 0, d = 0, m_rb = 0, r;
  reg wd = 0, ta = 0, pd = 0, rv = 0, sz = 1;
  wire [7:0] reg_rdata, byte_in, byte_wr_addr;
  wire done_ok, done_abort, byte_rx, byte_wr, eesize_xfer, eesize_now;
  integer n_fail = 0, tests_run = 0, cyc = 0, i;
  always #20 mclk = ~mclk;
  sib_bridge_status u_dut(.*);
  sib_eeprom_model u_far(.*);
  task conclude;
    begin
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task rd(input [7:0] ad, input [7:0] ex);
    begin
      @(posedge mclk) {reg_addr, reg_rd} <= {ad, 1'b1};
      @(posedge mclk) reg_rd <= 1'b0;
      #1 tests_run = tests_run + 1;
      if (reg_rdata !== ex)
      begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h expected %h", $time, reg_rdata, ex);
      end
    end
  endtask
  task wr(input [7:0] ad, input [7:0] dt);
    begin
      @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {ad, dt, 1'b1};
      @(posedge mclk) reg_wr <= 1'b0;
    end
  endtask
  // Bench model follows each command to its end
  task cmd(input wv, input ab, input [7:0] av, input [7:0] dv);
    begin
      @(posedge mclk) {cmd_wr, cmd_rd, abort, a, d} <= {wv, !wv, ab, av, dv};
      @(posedge mclk) {cmd_wr, cmd_rd} <= 2'h0;
      repeat (4) @(posedge mclk);
      if (wv)
        {wd, pd} = {!ab, (av & 8'h3F) == 8'h3F};
      else if (!ab)
        {rv, m_rb} = {1'b1, dv};
      ta = ab;
      if (ab)
        {wd, rv} = 2'h0;
    end
  endtask
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  initial
  begin
    void'($urandom(32'h3101));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h58, 8'h10);
    rd(8'h59, 8'h00);
    rd(8'h5A, 8'h00);
    wr(8'h59, 8'hFF);
    wr(8'h58, 8'hEF);
    sz = 1'b0;
    rd(8'h58, 8'h00);
    for (i = 0; i < 40; i = i + 1)
    begin
      r = $urandom;
      wr(8'h58, r);
      sz = r[4];
      cmd((i == 0) | $urandom, (i > 0) & $urandom, (i < 2) ? 8'h3F : $urandom, $urandom);
      rd(8'h58, {3'h0, sz, rv, pd, ta, wd});
      rd(8'h59, m_rb);
    end
    conclude;
  end
endmodule // tb_top
